// ===== logic/cvword_regs.svh
/*
 * register offsets, field positions, reset values and selector codes of the
 * converter data-word block.
 * assumes a 16-bit register port; offsets are word indices on that port.
 */
`ifndef CVWORD_REGS_SVH
`define CVWORD_REGS_SVH

`define CVW_ADDR_W          4
`define CVW_OFF_CTRL        4'h0
`define CVW_OFF_DATA        4'h4
`define CVW_OFF_STATUS      4'h6

`define CVW_DATA_RESET      16'h0000
`define CVW_CTRL_RESET      16'h0000
`define CVW_CODE_MSB        11
`define CVW_CODE_W          12
`define CVW_UNUSED_LSB      12

`define CVW_CTRL_RES_BIT    12
`define CVW_CTRL_LSEL_HI    11
`define CVW_CTRL_LSEL_LO    10
`define CVW_CTRL_FMT_BIT    4
`define CVW_CTRL_ENC_BIT    1
`define CVW_LSEL_IMMEDIATE  2'h0

`define CVW_SYNC_STAGES     3

`endif

// ===== logic/cvword_pkg.sv
/*
 * types shared by the converter data-word block.
 * assumes cvword_regs.svh for numeric constants.
 */
package cvword_pkg;

   typedef enum logic {
      CVW_RES_12 = 1'b0,
      CVW_RES_8  = 1'b1
   } cvword_res_t;

   typedef enum logic {
      CVW_FMT_BINARY = 1'b0,
      CVW_FMT_TWOS   = 1'b1
   } cvword_fmt_t;

   typedef struct packed {
      cvword_res_t resolution;
      cvword_fmt_t format;
      logic [1:0]  load_trigger_select;
      logic        conversion_enable;
   } cvword_ctrl_t;

   typedef struct packed {
      logic [11:0] code;
      logic        sign;
      logic        load;
   } cvword_core_t;

endpackage : cvword_pkg

// ===== logic/cvword_sync.sv
/*
 * three-flop synchroniser with agreement filter for a level from a pin.
 * assumes i_d is asynchronous to i_clk.
 */
`timescale 1ns/1ps
`include "cvword_regs.svh"

module cvword_sync (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_ce,
   input  wire logic i_d,
   output logic      o_q
);

   logic [`CVW_SYNC_STAGES-1:0] stage_reg;
   logic [`CVW_SYNC_STAGES-1:0] stage_next;
   logic                        q_reg;
   logic                        q_next;

   // stage 0 feeds stage 1 only; the filter watches stages 1 and 2
   always_comb begin
      stage_next = stage_reg;
      q_next     = q_reg;
      if (i_ce) begin
         stage_next = {stage_reg[`CVW_SYNC_STAGES-2:0], i_d};
         if (stage_reg[1] == stage_reg[2]) begin
            q_next = stage_reg[2];
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         stage_reg <= '0;
         q_reg     <= 1'b0;
      end else begin
         stage_reg <= stage_next;
         q_reg     <= q_next;
      end
   end

   assign o_q = q_reg;

endmodule : cvword_sync

// ===== logic/cvword_top.sv
/*
 * data-word register of a 12-bit converter channel, with the resolution,
 * format and load-trigger selections it needs, and the latch feeding the core.
 * assumes a single-cycle register port and an external trigger pin that idles
 * low; pin pulses shorter than two clocks may be lost in the synchroniser.
 * the core is expected to take o_core_code while o_core_load is high, and
 * every output leaves straight from a flop.
 */
// The address map and the address-and-strobe port were chosen for this implementation.
// Behaviour
// R1: upper four data bits read zero and never reach the converter core.
// R2: bits 11..0 hold the readable, writable code, cleared at reset.
// R3: 12-bit binary: code right-justified, bit 11 is most significant.
// R4: 12-bit two's complement: right-justified, bit 11 is the sign.
// R5: 8-bit binary: bit 7 most significant, bits 11..8 ignored.
// R6: 8-bit two's complement: bit 7 is sign, bits 11..8 ignored.
// R7: resolution select zero means 12-bit, one means 8-bit.
// R8: format select zero means straight binary, one two's complement.
// R9: trigger select zero loads the latch on write, ignoring conversion enable.
// R10: writes to the four upper data bits are discarded.
`timescale 1ns/1ps
`include "cvword_regs.svh"

module cvword_top (
   input  wire logic                      i_clk,
   input  wire logic                      i_rst,
   input  wire logic                      i_ce,
   input  wire logic [`CVW_ADDR_W-1:0]    i_addr,
   input  wire logic [15:0]               i_wdata,
   input  wire logic                      i_wr,
   input  wire logic                      i_rd,
   input  wire logic                      i_trigger,
   output logic      [15:0]               o_rdata,
   output logic      [11:0]               o_core_code,
   output logic                           o_core_sign,
   output logic                           o_core_load
);

   ////////////////////////////////////////////////////////////////////////////
   // decode

   function automatic logic hit(input logic [`CVW_ADDR_W-1:0] a,
                                input logic [`CVW_ADDR_W-1:0] off);
      hit = (a == off);
   endfunction : hit

   // unmapped indices fall through: writes dropped, reads answer zero
   logic wr_ctrl;
   logic wr_data;
   assign wr_ctrl = i_ce && i_wr && hit(i_addr, `CVW_OFF_CTRL);
   assign wr_data = i_ce && i_wr && hit(i_addr, `CVW_OFF_DATA);

   ////////////////////////////////////////////////////////////////////////////
   // trigger pin, synchronised then edge-detected

   logic trig_sync;
   logic trig_prev_reg;
   logic trig_prev_next;
   logic trig_rise;

   cvword_sync u_trig_sync (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .i_ce  (i_ce),
      .i_d   (i_trigger),
      .o_q   (trig_sync)
   );

   // edge reaches the latch four to five clocks after the pin rises
   // prev flop resets low to match the idle pin, so reset makes no false edge
   assign trig_rise = trig_sync && !trig_prev_reg;

   ////////////////////////////////////////////////////////////////////////////
   // registers

   cvword_pkg::cvword_ctrl_t ctrl_reg;
   cvword_pkg::cvword_ctrl_t ctrl_next;
   logic [11:0]              code_reg;
   logic [11:0]              code_next;
   logic [11:0]              latch_reg;
   logic [11:0]              latch_next;
   logic                     load_reg;
   logic                     load_next;
   logic                     pending_reg;
   logic                     pending_next;
   logic [15:0]              rdata_reg;
   logic [15:0]              rdata_next;
   logic                     do_load;

   // triggered modes need conversion enable; immediate mode loads on write
   // a write and a pin edge in one cycle load the written word only once
   always_comb begin
      do_load = 1'b0;
      if (ctrl_reg.load_trigger_select == `CVW_LSEL_IMMEDIATE) begin
         do_load = wr_data; // R9
      end else if (ctrl_reg.conversion_enable && i_ce) begin
         do_load = (ctrl_reg.load_trigger_select == 2'h1) ? wr_data : trig_rise;
      end
   end

   always_comb begin
      ctrl_next      = ctrl_reg;
      code_next      = code_reg;
      latch_next     = latch_reg;
      load_next      = load_reg;
      pending_next   = pending_reg;
      trig_prev_next = trig_prev_reg;
      rdata_next     = rdata_reg;
      // clock enable low holds everything, read data and load pulse included
      if (i_ce) begin
         load_next      = 1'b0;
         rdata_next     = 16'h0000;
         trig_prev_next = trig_sync;
         if (wr_ctrl) begin
            ctrl_next.resolution          = cvword_pkg::cvword_res_t'(i_wdata[`CVW_CTRL_RES_BIT]); // R7
            ctrl_next.format              = cvword_pkg::cvword_fmt_t'(i_wdata[`CVW_CTRL_FMT_BIT]); // R8
            ctrl_next.load_trigger_select = i_wdata[`CVW_CTRL_LSEL_HI:`CVW_CTRL_LSEL_LO];
            ctrl_next.conversion_enable   = i_wdata[`CVW_CTRL_ENC_BIT];
         end
         if (wr_data) begin
            code_next    = i_wdata[`CVW_CODE_MSB:0]; // R2 R10
            pending_next = 1'b1;
         end
         if (do_load) begin
            // new written value wins over the old one in the same cycle
            latch_next   = wr_data ? i_wdata[`CVW_CODE_MSB:0] : code_reg;
            load_next    = 1'b1;
            pending_next = 1'b0;
         end
         if (i_rd) begin
            unique case (i_addr)
               `CVW_OFF_CTRL: begin
                  rdata_next[`CVW_CTRL_RES_BIT] = ctrl_reg.resolution;
                  rdata_next[`CVW_CTRL_FMT_BIT] = ctrl_reg.format;
                  rdata_next[`CVW_CTRL_LSEL_HI:`CVW_CTRL_LSEL_LO] = ctrl_reg.load_trigger_select;
                  rdata_next[`CVW_CTRL_ENC_BIT] = ctrl_reg.conversion_enable;
               end
               `CVW_OFF_DATA: begin
                  rdata_next = {4'h0, code_reg}; // R1
               end
               // bit 12: written but not yet loaded; bits 11..0: the latch
               `CVW_OFF_STATUS: begin
                  rdata_next = {3'h0, pending_reg, latch_reg};
               end
               default: begin
                  rdata_next = 16'h0000;
               end
            endcase
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_reg      <= '0;
         code_reg      <= 12'h000;
         latch_reg     <= 12'h000;
         load_reg      <= 1'b0;
         pending_reg   <= 1'b0;
         trig_prev_reg <= 1'b0;
         rdata_reg     <= `CVW_DATA_RESET;
      end else begin
         ctrl_reg      <= ctrl_next;
         code_reg      <= code_next;
         latch_reg     <= latch_next;
         load_reg      <= load_next;
         pending_reg   <= pending_next;
         trig_prev_reg <= trig_prev_next;
         rdata_reg     <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // core code: right-justified, masked and offset per mode, sign on its own output

   // two's complement becomes offset binary by flipping the sign bit;
   // eight-bit mode masks bits 11..8 so they never reach the core
   function automatic cvword_pkg::cvword_core_t core_map(input cvword_pkg::cvword_ctrl_t c,
                                                         input logic [11:0]              v,
                                                         input logic                     ld);
      cvword_pkg::cvword_core_t r;
      r.load = ld;
      // sign output rises only in two's complement mode
      if (c.resolution == cvword_pkg::CVW_RES_8) begin
         r.code = {4'h0, v[7:0]}; // R5 R6
         r.sign = (c.format == cvword_pkg::CVW_FMT_TWOS) && v[7]; // R6
         if (c.format == cvword_pkg::CVW_FMT_TWOS) begin
            r.code[7] = ~v[7]; // R6 R8
         end
      end else begin
         r.code = v; // R3 R4
         r.sign = (c.format == cvword_pkg::CVW_FMT_TWOS) && v[`CVW_CODE_MSB]; // R4
         if (c.format == cvword_pkg::CVW_FMT_TWOS) begin
            r.code[`CVW_CODE_MSB] = ~v[`CVW_CODE_MSB]; // R4 R8
         end
      end
      return r;
   endfunction : core_map

   cvword_pkg::cvword_core_t core_reg;
   cvword_pkg::cvword_core_t core_next;

   // built from next-state values, so code and load pulse land together
   always_comb begin
      core_next = core_map(ctrl_next, latch_next, load_next);
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         core_reg <= '0;
      end else begin
         core_reg <= core_next;
      end
   end

   assign o_core_code = core_reg.code;
   assign o_core_sign = core_reg.sign;
   assign o_core_load = core_reg.load;
   assign o_rdata     = rdata_reg;

endmodule : cvword_top

// ===== verification/cvword_chk.sv
/* port assertions for the converter data-word block.
   assumes it is bound onto cvword_top and sees only its ports. */
`timescale 1ns/1ps
module cvword_chk (
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_ce,
   input wire logic [3:0]  i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic        i_trigger,
   input wire logic [15:0] o_rdata,
   input wire logic [11:0] o_core_code,
   input wire logic        o_core_sign,
   input wire logic        o_core_load
);
////////////////////////////////////////////////////////////////
// shadow of control, so each data write knows its mode
logic [15:0] ctl_reg;
wire ld = i_ce && i_wr && i_addr == 4'h4 && ctl_reg[11:10] == 2'h0;
always_ff @(posedge i_clk or posedge i_rst) begin
   if (i_rst) ctl_reg <= 16'h0000;
   else if (i_ce && i_wr && i_addr == 4'h0) ctl_reg <= i_wdata;
end
default clocking @(posedge i_clk); endclocking
default disable iff (i_rst);
////////////////////////////////////////////////////////////////
a_read_upper_zero: assert property (
   i_ce && i_rd && i_addr == 4'h4 |=> o_rdata[15:12] == 4'h0) else $error("data read upper bits set");
a_read_idle_zero: assert property (
   !(i_ce && i_rd) |=> o_rdata == ($past(i_ce) ? 16'h0000 : $past(o_rdata)))
   else $error("read data outside answer cycle");
a_write_loads: assert property (
   ld |=> o_core_load) else $error("immediate write did not load");
a_code_12_bin: assert property (
   ld && !ctl_reg[12] && !ctl_reg[4] |=> o_core_code == $past(i_wdata[11:0]) && !o_core_sign)
   else $error("12-bit binary code wrong");
a_code_12_twos: assert property (
   ld && !ctl_reg[12] && ctl_reg[4] |=> {o_core_sign, o_core_code} ==
   {$past(i_wdata[11]), ~$past(i_wdata[11]), $past(i_wdata[10:0])}) else $error("12-bit signed code wrong");
a_code_8_bin: assert property (
   ld && ctl_reg[12] && !ctl_reg[4] |=> {o_core_sign, o_core_code} == {5'h00, $past(i_wdata[7:0])})
   else $error("8-bit binary code wrong");
a_code_8_twos: assert property (
   ld && ctl_reg[12] && ctl_reg[4] |=> {o_core_sign, o_core_code} ==
   {$past(i_wdata[7]), 4'h0, ~$past(i_wdata[7]), $past(i_wdata[6:0])}) else $error("8-bit signed code wrong");
a_code_holds: assert property (
   !o_core_load && !$past(i_ce && i_wr && i_addr == 4'h0) |-> $stable(o_core_code))
   else $error("core code moved without load");
endmodule : cvword_chk

// ===== verification/dac_data_word_register_test.sv
/* self-checking bench for the converter data-word block.
   assumes cvword_top and the checker cvword_chk are compiled beside it. */
`timescale 1ns/1ps
module dac_data_word_register_test;
logic        i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_trigger = 1'b0;
logic [3:0]  i_addr = 4'h0;
logic [15:0] i_wdata = 16'h0000, o_rdata, w;
logic [11:0] o_core_code;
logic        o_core_sign, o_core_load;
logic [12:0] e;
int          failures = 0, n_tests = 0;
always #50 i_clk = ~i_clk;
cvword_top i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .i_trigger(i_trigger), .o_rdata(o_rdata), .o_core_code(o_core_code),
   .o_core_sign(o_core_sign), .o_core_load(o_core_load));
////////////////////////////////////////////////////////////////
// sign and offset-binary code the core should see
function automatic logic [12:0] core_of(input logic r, input logic f, input logic [15:0] d);
   if (r) return {f & d[7], 4'h0, d[7] ^ f, d[6:0]};
   return {f & d[11], d[11] ^ f, d[10:0]};
endfunction : core_of
task chk(input logic [15:0] seen, input logic [15:0] exp_v);
   n_tests++;
   if (seen !== exp_v) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp_v);
   end
endtask : chk
// strobes stay up until the next call, so calls may follow without a gap
task op(input logic ws, input logic rs, input logic [3:0] a, input logic [15:0] d);
   i_wr <= ws;
   i_rd <= rs;
   i_addr <= a;
   i_wdata <= d;
   @(posedge i_clk);
endtask : op
task rd(input logic [3:0] a);
   op(1'b0, 1'b1, a, 16'h0000);
   #1;
endtask : rd
task print_verdict;
   if (failures == 0 && n_tests > 0) $display("Testbench passed");
   else $display("Testbench failed");
   $finish;
endtask : print_verdict
////////////////////////////////////////////////////////////////
initial begin
   #200000;
   failures++;
   print_verdict();
end
initial begin
   repeat (12) @(posedge i_clk);
   i_rst <= 1'b0;
   void'($urandom(32'hA34A));
   rd(4'h0); chk(o_rdata, 16'h0000);
   rd(4'h4); chk(o_rdata, 16'h0000);
   for (int m = 0; m < 4; m++) begin
      w = {3'h0, m[1], 7'h00, m[0], 4'h0};
      op(1'b1, 1'b0, 4'h0, w);
      rd(4'h0); chk(o_rdata, w);
      for (int k = 0; k < 8; k++) begin
         w = (k == 0) ? 16'hFFFF : 16'($urandom);
         op(1'b1, 1'b0, 4'h4, w);
         #1;
         e = core_of(m[1], m[0], w);
         chk({15'h0000, o_core_load}, 16'h0001);
         chk({3'h0, o_core_sign, o_core_code}, {3'h0, e});
         rd(4'h4); chk(o_rdata, w & 16'h0FFF);
      end
   end
   // non-immediate trigger, enable off: word stored but latch untouched
   op(1'b1, 1'b0, 4'h0, 16'h1410);
   op(1'b1, 1'b0, 4'h4, 16'h0123);
   #1;
   chk({15'h0000, o_core_load}, 16'h0000);
   chk({3'h0, o_core_sign, o_core_code}, {3'h0, e});
   i_ce <= 1'b0;
   op(1'b1, 1'b0, 4'h4, 16'h0555);
   i_ce <= 1'b1;
   rd(4'h4); chk(o_rdata, 16'h0123);
   op(1'b1, 1'b0, 4'h8, 16'hFFFF);
   rd(4'h8); chk(o_rdata, 16'h0000);
   // write-triggered load with enable, then a pin-triggered load
   op(1'b1, 1'b0, 4'h0, 16'h0402);
   op(1'b1, 1'b0, 4'h4, 16'h0ABC);
   #1;
   chk({15'h0000, o_core_load}, 16'h0001);
   chk({3'h0, o_core_sign, o_core_code}, {3'h0, core_of(1'b0, 1'b0, 16'h0ABC)});
   op(1'b1, 1'b0, 4'h0, 16'h0802);
   op(1'b1, 1'b0, 4'h4, 16'h0123);
   #1;
   chk({15'h0000, o_core_load}, 16'h0000);
   rd(4'h6); chk(o_rdata, 16'h1ABC);
   i_trigger <= 1'b1;
   op(1'b0, 1'b0, 4'h0, 16'h0000);
   repeat (4) @(posedge i_clk);
   #1;
   chk({15'h0000, o_core_load}, 16'h0001);
   chk({3'h0, o_core_sign, o_core_code}, 16'h0123);
   rd(4'h6); chk(o_rdata, 16'h0123);
   // reset in mid-run clears the stored code and the core side
   i_trigger <= 1'b0;
   i_rst <= 1'b1;
   repeat (2) @(posedge i_clk);
   i_rst <= 1'b0;
   rd(4'h4); chk(o_rdata, 16'h0000);
   chk({3'h0, o_core_sign, o_core_code}, 16'h0000);
   op(1'b0, 1'b0, 4'h0, 16'h0000);
   print_verdict();
end
endmodule : dac_data_word_register_test
bind cvword_top cvword_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .i_trigger(i_trigger), .o_rdata(o_rdata), .o_core_code(o_core_code),
   .o_core_sign(o_core_sign), .o_core_load(o_core_load));
